// ==== logic/ipl_pkg.sv ====
package boot_seq_pkg;
   // register map, byte addresses on the bus
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   // control field layout
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_OPT_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // panel load modes
   localparam logic [3:0] MODE_DISK = 4'h0;
   localparam logic [3:0] MODE_DSKT = 4'he;
   localparam logic [3:0] MODE_OPT = 4'hf;
   // panel display values
   localparam logic [15:0] DISPLAY_BUSY = 16'hffff;
   localparam logic [15:0] DISPLAY_IDLE = 16'h0000;
   // self-test image size and control storage address width
   localparam int TEST_WORDS = 4;
   localparam int CS_AW = 12;
   localparam logic [15:0] SELFTEST_BASE = 16'h5a00;
   // timing
   localparam int CLK_NS = 10;
   localparam int BIT_RESET_NS = 20;
   localparam int BIT_RESET_CYC = (BIT_RESET_NS + CLK_NS - 1) / CLK_NS;
   // sequencer states, gray coded along the load path
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_STOP = 3'b001,
      ST_ERRREC = 3'b011,
      ST_PCBRST = 3'b010,
      ST_SELFLOAD = 3'b110,
      ST_START = 3'b111,
      ST_WAITHW = 3'b101,
      ST_LOADCYC = 3'b100
   } seq_state_e;
endpackage : boot_seq_pkg

// ==== logic/initial_program_load_sequencer.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// [R1] mode 0 loads from disk
// [R2] mode E loads from diskette
// [R3] mode F source from load option
// [R4] load key press starts hardware load
// [R5] processor loads main storage afterwards
// [R6] display shows FFFF at start
// [R7] processor drops running, stops cycle steals
// [R8] error recording only when needed
// [R9] issue processor control bit reset
// [R10] write self-test routines to control storage
// [R11] send start command to processor
// [R12] processor runs its self-test
// [R13] processor returns hardware load command
// [R14] after system reset assert microcode load cycle
// [R15] steps run strictly in order
module initial_program_load_sequencer
   import boot_seq_pkg::*;
#(
   parameter int N_WORDS = TEST_WORDS,
   parameter int AW = CS_AW
)(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [31:0] hrdata_out,
   input wire logic load_key_in,
   input wire logic control_proc_running_in,
   input wire logic error_pending_in,
   input wire logic err_record_done_in,
   input wire logic hw_load_cmd_in,
   input wire logic load_done_in,
   output logic [15:0] display_out,
   output logic err_record_out,
   output logic ctrl_bit_reset_out,
   output logic cs_we_out,
   output logic [AW-1:0] cs_addr_out,
   output logic [15:0] cs_data_out,
   output logic start_cmd_out,
   output logic sys_reset_out,
   output logic microcode_load_cycle_out,
   output logic load_from_disk_out,
   output logic load_from_diskette_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // elaboration check
   if (N_WORDS < 1 || N_WORDS > (1 << AW) || AW > 16)
      $error("self-test size does not fit control storage");

   // self-test image, one word per address
   function automatic logic [15:0] selftest_word(input logic [AW-1:0] idx);
      return SELFTEST_BASE ^ 16'(idx);
   endfunction : selftest_word

   // true when the panel mode names a load source
   function automatic logic mode_valid(input logic [3:0] m);
      return (m == MODE_DISK) || (m == MODE_DSKT) || (m == MODE_OPT);
   endfunction : mode_valid

   seq_state_e state_q, state_d;
   logic [4:0] ctrl_q;
   logic key_prev_q;
   logic err_need_q;
   logic [AW-1:0] wrd_q;
   logic [1:0] bit_rst_cnt_q;
   logic wr_pend_q;
   logic [7:0] addr_q;
   logic key_go;
   logic [3:0] mode;
   logic opt;

   assign mode = ctrl_q[CTRL_MODE_LSB +: 4];
   assign opt = ctrl_q[CTRL_OPT_BIT];
   // [R4] key edge start
   assign key_go = load_key_in && !key_prev_q && (state_q == ST_IDLE) && mode_valid(mode);

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait, always okay
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         hreadyout_out <= 1'b0;
         hresp_out <= 1'b0;
      end
      else
      begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   // address phase capture and read data
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata_out <= 32'h0000_0000;
      end
      else if (hready_in)
      begin
         wr_pend_q <= hsel_in && htrans_in[1] && hwrite_in;
         addr_q <= haddr_in[7:0];
         if (hsel_in && htrans_in[1] && !hwrite_in && haddr_in[7:0] == CTRL_OFS)
            hrdata_out <= {27'h0, ctrl_q};
         else if (hsel_in && htrans_in[1] && !hwrite_in && haddr_in[7:0] == STATUS_OFS)
            hrdata_out <= {10'h0, display_out, load_from_diskette_out,
                           load_from_disk_out, microcode_load_cycle_out, state_q};
         else
            hrdata_out <= 32'h0000_0000;
      end
   end

   // control register write
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         ctrl_q <= CTRL_RESET;
      else if (wr_pend_q && addr_q == CTRL_OFS)
         ctrl_q <= hwdata_in[4:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (key_go)
               state_d = ST_STOP;
         // [R7] wait processor stop
         ST_STOP:
            if (!control_proc_running_in)
               state_d = ST_ERRREC;
         // [R8] skip when unneeded
         ST_ERRREC:
            if (!err_need_q || err_record_done_in)
               state_d = ST_PCBRST;
         // [R15] ordered step hand-off
         ST_PCBRST:
            if (bit_rst_cnt_q == 2'(BIT_RESET_CYC - 1))
               state_d = ST_SELFLOAD;
         ST_SELFLOAD:
            if (wrd_q == AW'(N_WORDS - 1))
               state_d = ST_START;
         ST_START:
            state_d = ST_WAITHW;
         // [R13] await hardware load command
         ST_WAITHW:
            if (hw_load_cmd_in)
               state_d = ST_LOADCYC;
         ST_LOADCYC:
            if (load_done_in)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // state and step counters
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_q <= ST_IDLE;
         key_prev_q <= 1'b0;
         bit_rst_cnt_q <= 2'd0;
         wrd_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         key_prev_q <= load_key_in;
         bit_rst_cnt_q <= (state_q == ST_PCBRST) ? bit_rst_cnt_q + 2'd1 : 2'd0;
         wrd_q <= (state_q == ST_SELFLOAD) ? wrd_q + AW'(1) : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // display and source selection, latched at the key
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         display_out <= DISPLAY_IDLE;
         err_need_q <= 1'b0;
         load_from_disk_out <= 1'b0;
         load_from_diskette_out <= 1'b0;
      end
      else if (key_go)
      begin
         // [R6] show busy value
         display_out <= DISPLAY_BUSY;
         err_need_q <= error_pending_in;
         // [R1] [R3] disk source
         load_from_disk_out <= (mode == MODE_DISK) || (mode == MODE_OPT && !opt);
         // [R2] [R3] diskette source
         load_from_diskette_out <= (mode == MODE_DSKT) || (mode == MODE_OPT && opt);
      end
      else if (state_q == ST_LOADCYC && load_done_in)
      begin
         display_out <= DISPLAY_IDLE;
         load_from_disk_out <= 1'b0;
         load_from_diskette_out <= 1'b0;
      end
   end

   // step strobes toward the processor and storage
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         err_record_out <= 1'b0;
         ctrl_bit_reset_out <= 1'b0;
         cs_we_out <= 1'b0;
         cs_addr_out <= '0;
         cs_data_out <= 16'h0000;
         start_cmd_out <= 1'b0;
         sys_reset_out <= 1'b0;
      end
      else
      begin
         // [R8] record only when pending
         err_record_out <= (state_q == ST_ERRREC) && err_need_q && !err_record_done_in;
         // [R9] control bit reset
         ctrl_bit_reset_out <= (state_q == ST_PCBRST);
         // [R10] self-test image write
         cs_we_out <= (state_q == ST_SELFLOAD);
         cs_addr_out <= wrd_q;
         cs_data_out <= selftest_word(wrd_q);
         // [R11] start command pulse
         start_cmd_out <= (state_q == ST_START);
         sys_reset_out <= (state_q == ST_WAITHW) && hw_load_cmd_in;
      end
   end

   // microcode load cycle, follows the system reset
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         microcode_load_cycle_out <= 1'b0;
      // [R14] load cycle after reset
      else
         microcode_load_cycle_out <= sys_reset_out || (microcode_load_cycle_out && !load_done_in);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   logic [AW:0] chk_wr_q;
   always_ff @(posedge clk_in)
   begin
      if (rst_in || key_go)
         chk_wr_q <= '0;
      else if (cs_we_out)
         chk_wr_q <= chk_wr_q + (AW+1)'(1);
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_accept;
      key_go;
   endsequence
   sequence s_bit_rst_pulse;
      ctrl_bit_reset_out [*2] ##1 !ctrl_bit_reset_out;
   endsequence

   a_display_busy: assert property (s_accept |=> display_out == DISPLAY_BUSY) // [R6]
      else $error("display not busy after key");
   a_disk_source: assert property (s_accept and mode == MODE_DISK |=> // [R1]
      load_from_disk_out && !load_from_diskette_out)
      else $error("mode 0 not disk");
   a_dskt_source: assert property (s_accept and mode == MODE_DSKT |=> // [R2]
      load_from_diskette_out && !load_from_disk_out)
      else $error("mode E not diskette");
   a_opt_source: assert property (s_accept and mode == MODE_OPT |=> // [R3]
      load_from_diskette_out == $past(opt) && load_from_disk_out == !$past(opt))
      else $error("mode F source wrong");
   a_key_starts: assert property ($rose(state_q != ST_IDLE) |-> $past(key_go)) // [R4]
      else $error("sequence began without key");
   a_err_gate: assert property (err_record_out |-> err_need_q) // [R8]
      else $error("error recording not needed");
   a_bit_rst_width: assert property ($rose(ctrl_bit_reset_out) |-> s_bit_rst_pulse) // [R9]
      else $error("control bit reset width wrong");
   a_selftest_count: assert property ($rose(start_cmd_out) |-> // [R10]
      chk_wr_q == (AW+1)'(N_WORDS) && !cs_we_out)
      else $error("self-test word count wrong");
   a_start_order: assert property ($rose(start_cmd_out) |-> $past(cs_we_out) ##1 // [R11]
      !start_cmd_out)
      else $error("start command out of order");
   a_step_order: assert property ($rose(cs_we_out) |-> $past(ctrl_bit_reset_out)) // [R15]
      else $error("self-test load before reset");
   a_load_cycle: assert property ($rose(microcode_load_cycle_out) |-> // [R14]
      $past(sys_reset_out) && !sys_reset_out)
      else $error("load cycle without system reset");
endmodule : initial_program_load_sequencer

// ==== tb/cs_proc_model.sv ====
`timescale 1ns/10ps
module cs_proc_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] lat_in,
   input wire logic [15:0] display_in,
   input wire logic err_record_in,
   input wire logic start_cmd_in,
   input wire logic microcode_load_cycle_in,
   output logic control_proc_running_out,
   output logic err_record_done_out,
   output logic hw_load_cmd_out,
   output logic load_done_out
);
   logic [3:0] cnt_q;
   logic pend_q;
   logic busy;
   // something is waiting for an answer from this side
   assign busy = (control_proc_running_out && display_in == 16'hffff) || err_record_in ||
      pend_q || (microcode_load_cycle_in && !load_done_out);
   // one up-counter paces every answer, lat_in + 1 cycles after busy rises
   always_ff @(posedge clk_in)
   begin
      err_record_done_out <= 1'b0;
      hw_load_cmd_out <= 1'b0;
      load_done_out <= 1'b0;
      if (start_cmd_in)
         pend_q <= 1'b1;
      if (load_done_out)
         control_proc_running_out <= 1'b1;
      if (!busy)
         cnt_q <= 4'h0;
      else if (cnt_q != lat_in)
         cnt_q <= cnt_q + 4'h1;
      else
      begin
         cnt_q <= 4'h0;
         if (control_proc_running_out && display_in == 16'hffff)
            control_proc_running_out <= 1'b0;
         else if (err_record_in)
            err_record_done_out <= 1'b1;
         else if (pend_q)
         begin
            hw_load_cmd_out <= 1'b1;
            pend_q <= 1'b0;
         end
         else
            load_done_out <= 1'b1;
      end
      if (rst_in)
      begin
         control_proc_running_out <= 1'b1;
         cnt_q <= 4'h0;
         pend_q <= 1'b0;
      end
   end
endmodule : cs_proc_model

// ==== tb/tb_initial_program_load_sequencer.sv ====
`timescale 1ns/10ps
module tb_initial_program_load_sequencer;
   import boot_seq_pkg::*;
   logic clk, rst, hsel, hwrite, hrdy, key, err_pend, run, erd, hwl, ldone, hresp;
   logic ew, cbr, we, st, sr, mlc, dk, dt;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [15:0] disp, csd;
   logic [11:0] csa;
   logic [3:0] lat;
   int checked, mismatches, cbr_n, we_n, st_n, sr_n, er_n, mlc_n, cyc;

   initial_program_load_sequencer u_dut (.clk_in(clk), .rst_in(rst), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
      .hrdata_out(hrdata), .load_key_in(key), .control_proc_running_in(run),
      .error_pending_in(err_pend), .err_record_done_in(erd), .hw_load_cmd_in(hwl),
      .load_done_in(ldone), .display_out(disp), .err_record_out(ew), .ctrl_bit_reset_out(cbr),
      .cs_we_out(we), .cs_addr_out(csa), .cs_data_out(csd), .start_cmd_out(st),
      .sys_reset_out(sr), .microcode_load_cycle_out(mlc), .load_from_disk_out(dk),
      .load_from_diskette_out(dt));
   cs_proc_model u_proc (.clk_in(clk), .rst_in(rst), .lat_in(lat), .display_in(disp),
      .err_record_in(ew), .start_cmd_in(st), .microcode_load_cycle_in(mlc),
      .control_proc_running_out(run), .err_record_done_out(erd), .hw_load_cmd_out(hwl),
      .load_done_out(ldone));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   // single word transfer, waits on the slave's ready
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic press();
      key <= 1'b1;
      @(posedge clk);
      key <= 1'b0;
   endtask : press
   ////////////////////////////////////////////////////////////////////////////////
   task automatic regs();
      ahb(1'b0, CTRL_OFS, 32'h0);
      check("ctrl reset", rd, 32'h0);
      check("okay response", {31'h0, hresp}, 32'h0);
      ahb(1'b0, 8'h40, 32'h0);
      check("unmapped", rd, 32'h0);
      ahb(1'b0, STATUS_OFS, 32'h0);
      check("idle status", rd, 32'h0);
      $display("test regs done");
   endtask : regs
   task automatic bad_mode();
      cbr_n = 0;
      ahb(1'b1, CTRL_OFS, 32'h1);
      press();
      repeat (4) @(posedge clk);
      check("bad mode display", disp, DISPLAY_IDLE);
      check("bad mode bit reset", cbr_n, 0);
      $display("test bad mode done");
   endtask : bad_mode
   // full load, with a second key press while busy
   task automatic load_run(input logic [4:0] c, input logic e, input logic [3:0] l,
      input logic xdk, input logic xdt);
      ahb(1'b1, CTRL_OFS, {27'h0, c});
      ahb(1'b0, CTRL_OFS, 32'h0);
      check("ctrl", rd, {27'h0, c});
      err_pend <= e;
      lat <= l;
      cbr_n = 0;
      we_n = 0;
      st_n = 0;
      sr_n = 0;
      er_n = 0;
      mlc_n = 0;
      press();
      repeat (2) @(posedge clk);
      check("display", disp, DISPLAY_BUSY);
      check("disk", dk, xdk);
      check("diskette", dt, xdt);
      ahb(1'b0, STATUS_OFS, 32'h0);
      check("status sources", {14'h0, rd[21:4]}, {14'h0, DISPLAY_BUSY, xdt, xdk});
      press();
      for (int i = 0; i < 400 && disp !== DISPLAY_IDLE; i++) @(posedge clk);
      check("display end", disp, DISPLAY_IDLE);
      check("bit reset cycles", cbr_n, BIT_RESET_CYC);
      check("writes", we_n, TEST_WORDS);
      check("starts", st_n, 1);
      check("recording", er_n != 0, e);
      check("system resets", sr_n, 1);
      check("load cycle", mlc_n != 0, 1);
      $display("test load %h done", c);
   endtask : load_run
   ////////////////////////////////////////////////////////////////////////////////
   // run limit: a hang counts as a mismatch and ends the run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         mismatches++;
         results();
      end
   end
   // step monitor: counts each step and checks that writes, start and load cycle follow the steps before them
   always @(posedge clk)
   begin
      if (ew)
         er_n++;
      if (cbr)
         cbr_n++;
      if (we)
      begin
         check("cs addr", {20'h0, csa}, we_n);
         check("cs data", {16'h0, csd}, {16'h0, SELFTEST_BASE ^ we_n[15:0]});
         check("bit reset before write", cbr_n, BIT_RESET_CYC);
         we_n++;
      end
      if (st)
      begin
         check("writes before start", we_n, TEST_WORDS);
         st_n++;
      end
      if (sr)
         sr_n++;
      if (mlc && mlc_n == 0)
         check("start and reset first", st_n + sr_n, 2);
      if (mlc)
         mlc_n++;
   end
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      key = 1'b0;
      err_pend = 1'b0;
      lat = 4'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      regs();
      load_run(5'h00, 1'b0, 4'h0, 1'b1, 1'b0);
      load_run(5'h0e, 1'b1, 4'h9, 1'b0, 1'b1);
      load_run(5'h0f, 1'b0, 4'h3, 1'b1, 1'b0);
      load_run(5'h1f, 1'b1, 4'h1, 1'b0, 1'b1);
      bad_mode();
      results();
   end
endmodule : tb_initial_program_load_sequencer
